// File: common/i2cra_pkg.sv
// package of constants for the two-wire register access link
// Function
// - address byte carries fixed seven-bit slave address
// - eighth address bit: zero write, one read
// - data changes only while clock low
// - start is data falling while clock high
// - stop is data rising while clock high
// - repeated start handled like first start
// - bus busy from start until stop
// - bytes are eight bits, msb first
// - transmitter releases, receiver pulls ack low
// - addressed receiver acknowledges every byte
// - master clocks the ninth acknowledge pulse
// - write: register index, then data byte
// - write applied at final ack rising edge
// - read preceded by write setting index
package i2cra_pkg;
    localparam logic [6:0] I2CRA_SLAVE_ADDR = 7'h1A;
    localparam logic       I2CRA_DIR_WRITE  = 1'h0;
    localparam logic       I2CRA_DIR_READ   = 1'h1;
    localparam int         I2CRA_BYTE_BITS  = 8;
    localparam int         I2CRA_REGS       = 256;
    localparam logic [7:0] I2CRA_REG_RESET  = 8'h00;
    // master timing: periods in ns, quarter bit in system clock cycles
    localparam int         I2CRA_CLK_NS     = 25;
    localparam int         I2CRA_LINK_NS    = 200;
    localparam int         I2CRA_QTR_CYC    = (I2CRA_LINK_NS / 4 + I2CRA_CLK_NS - 1) / I2CRA_CLK_NS;
    localparam logic [3:0] I2CRA_BIT_LAST   = 4'h8;
endpackage

// File: common/i2cra_if.sv
// interface joining master and slave over the shared two wires
interface i2cra_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    wire  scl;
    wire  sda;

    // open drain: a driving party pulls low, otherwise pulled high
    assign scl = !(scl_oe && !scl_o);
    assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

    modport slave (
        input  scl,
        input  sda,
        output sda_s_o,
        output sda_s_oe
    );
    modport master (
        input  scl,
        input  sda,
        output scl_o,
        output scl_oe,
        output sda_m_o,
        output sda_m_oe
    );
endinterface

// File: rtl/i2cra_sync.sv
// two flip-flop synchroniser with edge detection after the second stage
module i2cra_sync
    import i2cra_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      q,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } i2cra_sync_t;
    i2cra_sync_t st_r;
    i2cra_sync_t st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = din;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= 3'h7;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q    = st_r.s2;
    assign rise = st_r.s2 && !st_r.s3;
    assign fall = !st_r.s2 && st_r.s3;
endmodule

// File: rtl/i2cra_slave.sv
// slave end: register file reached over the two-wire link
module i2cra_slave
    import i2cra_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    i2cra_if.slave     bus,
    output logic       bus_busy,
    output logic       wr_strobe,
    output logic [7:0] wr_index,
    output logic [7:0] wr_data
);
    typedef enum logic [4:0] {
        I2CRA_S_IDLE = 5'h01,
        I2CRA_S_RECV = 5'h02,
        I2CRA_S_ACK  = 5'h04,
        I2CRA_S_SEND = 5'h08,
        I2CRA_S_MACK = 5'h10
    } i2cra_sst_t;

    typedef struct packed {
        i2cra_sst_t st;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [1:0] byten;
        logic       rd;
        logic       busy;
        logic [7:0] idx;
        logic       sda_o;
        logic       sda_oe;
        logic       wstb;
        logic [7:0] widx;
        logic [7:0] wdat;
    } i2cra_slv_t;

    i2cra_slv_t r_r;
    i2cra_slv_t r_nxt;
    logic [7:0] regs_r [I2CRA_REGS];
    logic       scl_q, scl_rise, scl_fall;
    logic       sda_q, sda_rise, sda_fall;

    i2cra_sync u_scl (.clk(clk), .rst_n(rst_n), .din(bus.scl),
                      .q(scl_q), .rise(scl_rise), .fall(scl_fall));
    i2cra_sync u_sda (.clk(clk), .rst_n(rst_n), .din(bus.sda),
                      .q(sda_q), .rise(sda_rise), .fall(sda_fall));

    always_comb begin
        r_nxt      = r_r;
        r_nxt.wstb = 1'b0;
        if (sda_fall && scl_q) begin
            r_nxt.st     = I2CRA_S_RECV;
            r_nxt.busy   = 1'b1;
            r_nxt.bitn   = 4'h0;
            r_nxt.byten  = 2'h0;
            r_nxt.sda_oe = 1'b0;
        end else if (sda_rise && scl_q) begin
            r_nxt.st     = I2CRA_S_IDLE;
            r_nxt.busy   = 1'b0;
            r_nxt.sda_oe = 1'b0;
        end else begin
            case (r_r.st)
                I2CRA_S_IDLE: begin
                    r_nxt.sda_oe = 1'b0;
                end
                I2CRA_S_RECV: begin
                    if (scl_rise) begin
                        r_nxt.sh   = {r_r.sh[6:0], sda_q};
                        r_nxt.bitn = r_r.bitn + 4'h1;
                    end else if (scl_fall && r_r.bitn == I2CRA_BIT_LAST) begin
                        r_nxt.bitn = 4'h0;
                        if (r_r.byten == 2'h0 && r_r.sh[7:1] != I2CRA_SLAVE_ADDR) begin
                            r_nxt.st = I2CRA_S_IDLE;
                        end else begin
                            r_nxt.st     = I2CRA_S_ACK;
                            r_nxt.sda_o  = 1'b0;
                            r_nxt.sda_oe = 1'b1;
                            if (r_r.byten == 2'h0) begin
                                r_nxt.rd = (r_r.sh[0] == I2CRA_DIR_READ);
                            end else if (r_r.byten == 2'h1) begin
                                r_nxt.idx = r_r.sh;
                            end
                        end
                    end
                end
                I2CRA_S_ACK: begin
                    if (scl_rise && r_r.byten == 2'h2) begin
                        r_nxt.wstb = 1'b1;
                        r_nxt.widx = r_r.idx;
                        r_nxt.wdat = r_r.sh;
                    end
                    if (scl_fall) begin
                        if (r_r.byten != 2'h3) begin
                            r_nxt.byten = r_r.byten + 2'h1;
                        end
                        if (r_r.rd) begin
                            r_nxt.st     = I2CRA_S_SEND;
                            r_nxt.sh     = regs_r[r_r.idx];
                            r_nxt.sda_o  = regs_r[r_r.idx][7];
                            r_nxt.sda_oe = 1'b1;
                            r_nxt.bitn   = 4'h1;
                        end else begin
                            r_nxt.st     = I2CRA_S_RECV;
                            r_nxt.sda_oe = 1'b0;
                            if (r_r.byten == 2'h2) begin
                                r_nxt.idx = r_r.idx + 8'h01;
                                r_nxt.byten = 2'h2;
                            end
                        end
                    end
                end
                I2CRA_S_SEND: begin
                    if (scl_fall) begin
                        if (r_r.bitn == I2CRA_BIT_LAST) begin
                            r_nxt.st     = I2CRA_S_MACK;
                            r_nxt.sda_oe = 1'b0;
                        end else begin
                            r_nxt.sh    = {r_r.sh[6:0], 1'b0};
                            r_nxt.sda_o = r_r.sh[6];
                            r_nxt.bitn  = r_r.bitn + 4'h1;
                        end
                    end
                end
                I2CRA_S_MACK: begin
                    if (scl_rise) begin
                        if (sda_q) begin
                            r_nxt.st = I2CRA_S_IDLE;
                        end else begin
                            r_nxt.idx = r_r.idx + 8'h01;
                            r_nxt.st  = I2CRA_S_ACK;
                        end
                    end
                end
                default: r_nxt.st = I2CRA_S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_r       <= '0;
            r_r.st    <= I2CRA_S_IDLE;
            r_r.sda_o <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < I2CRA_REGS; i++) begin
                regs_r[i] <= I2CRA_REG_RESET;
            end
        end else if (r_r.wstb) begin
            regs_r[r_r.widx] <= r_r.wdat;
        end
    end

    assign bus.sda_s_o  = r_r.sda_o;
    assign bus.sda_s_oe = r_r.sda_oe;
    assign bus_busy     = r_r.busy;
    assign wr_strobe    = r_r.wstb;
    assign wr_index     = r_r.widx;
    assign wr_data      = r_r.wdat;
endmodule

// File: rtl/i2cra_master.sv
// master end: one register write or one indexed read per request
module i2cra_master
    import i2cra_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    i2cra_if.master    bus,
    input  wire logic  req,
    input  wire logic  req_rd,
    input  wire logic [7:0] req_index,
    input  wire logic [7:0] req_data,
    output logic       busy,
    output logic       done,
    output logic       nack,
    output logic [7:0] rd_data
);
    typedef enum logic [5:0] {
        I2CRA_M_IDLE  = 6'h01,
        I2CRA_M_START = 6'h02,
        I2CRA_M_BIT   = 6'h04,
        I2CRA_M_STOP  = 6'h08,
        I2CRA_M_RSTA  = 6'h10,
        I2CRA_M_END   = 6'h20
    } i2cra_mst_t;

    typedef struct packed {
        i2cra_mst_t st;
        logic [1:0] ph;
        logic [7:0] qcnt;
        logic [3:0] bitn;
        logic [2:0] byten;
        logic [7:0] sh;
        logic       rd;
        logic [7:0] idx;
        logic [7:0] dat;
        logic       scl_o;
        logic       sda_o;
        logic       busy;
        logic       done;
        logic       nack;
        logic [7:0] rdat;
    } i2cra_mst_r_t;

    i2cra_mst_r_t r_r;
    i2cra_mst_r_t r_nxt;
    logic         tick;
    logic         sda_q;

    i2cra_sync u_sda (.clk(clk), .rst_n(rst_n), .din(bus.sda),
                      .q(sda_q), .rise(), .fall());

    assign tick = (r_r.qcnt == 8'(I2CRA_QTR_CYC - 1));

    // byte sent in each slot: 0 addr, 1 index, 2 data / 3 read addr, 4 read
    function automatic logic [7:0] slot_byte(input logic [2:0] n, input logic [7:0] i,
                                             input logic [7:0] d);
        case (n)
            3'h0:    slot_byte = {I2CRA_SLAVE_ADDR, I2CRA_DIR_WRITE};
            3'h1:    slot_byte = i;
            3'h2:    slot_byte = d;
            3'h3:    slot_byte = {I2CRA_SLAVE_ADDR, I2CRA_DIR_READ};
            default: slot_byte = 8'hFF;
        endcase
    endfunction

    always_comb begin
        r_nxt      = r_r;
        r_nxt.done = 1'b0;
        r_nxt.qcnt = tick ? 8'h00 : r_r.qcnt + 8'h01;
        case (r_r.st)
            I2CRA_M_IDLE: begin
                r_nxt.qcnt = 8'h00;
                if (req) begin
                    r_nxt.st    = I2CRA_M_START;
                    r_nxt.busy  = 1'b1;
                    r_nxt.nack  = 1'b0;
                    r_nxt.rd    = req_rd;
                    r_nxt.idx   = req_index;
                    r_nxt.dat   = req_data;
                    r_nxt.byten = 3'h0;
                    r_nxt.ph    = 2'h0;
                end
            end
            I2CRA_M_START, I2CRA_M_RSTA: begin
                if (tick) begin
                    r_nxt.ph = r_r.ph + 2'h1;
                    case (r_r.ph)
                        2'h0: r_nxt.sda_o = 1'b1;
                        2'h1: r_nxt.scl_o = 1'b1;
                        2'h2: r_nxt.sda_o = 1'b0;
                        default: begin
                            r_nxt.scl_o = 1'b0;
                            r_nxt.st    = I2CRA_M_BIT;
                            r_nxt.bitn  = 4'h0;
                            r_nxt.sh    = slot_byte(r_r.byten, r_r.idx, r_r.dat);
                        end
                    endcase
                end
            end
            I2CRA_M_BIT: begin
                if (tick) begin
                    r_nxt.ph = r_r.ph + 2'h1;
                    case (r_r.ph)
                        2'h0: begin
                            if (r_r.bitn == I2CRA_BIT_LAST) begin
                                // ack slot always released: the single read byte is nacked
                                r_nxt.sda_o = 1'b1;
                            end else begin
                                r_nxt.sda_o = (r_r.byten == 3'h4) ? 1'b1 : r_r.sh[7];
                            end
                        end
                        2'h1: r_nxt.scl_o = 1'b1;
                        2'h2: begin
                            if (r_r.bitn == I2CRA_BIT_LAST) begin
                                if (r_r.byten != 3'h4 && sda_q) begin
                                    r_nxt.nack = 1'b1;
                                end
                            end else begin
                                r_nxt.sh = {r_r.sh[6:0], sda_q};
                            end
                        end
                        default: begin
                            r_nxt.scl_o = 1'b0;
                            if (r_r.bitn != I2CRA_BIT_LAST) begin
                                r_nxt.bitn = r_r.bitn + 4'h1;
                            end else begin
                                r_nxt.bitn = 4'h0;
                                if (r_r.byten == 3'h4) begin
                                    r_nxt.rdat = r_r.sh;
                                end
                                if (r_r.nack || r_r.byten == 3'h4 ||
                                    (r_r.byten == 3'h2 && !r_r.rd)) begin
                                    r_nxt.st = I2CRA_M_STOP;
                                end else if (r_r.byten == 3'h1 && r_r.rd) begin
                                    r_nxt.st    = I2CRA_M_RSTA;
                                    r_nxt.byten = 3'h3;
                                end else begin
                                    r_nxt.byten = r_r.byten + 3'h1;
                                    r_nxt.sh    = slot_byte(r_r.byten + 3'h1, r_r.idx,
                                                            r_r.dat);
                                end
                            end
                        end
                    endcase
                end
            end
            I2CRA_M_STOP: begin
                if (tick) begin
                    r_nxt.ph = r_r.ph + 2'h1;
                    case (r_r.ph)
                        2'h0: r_nxt.sda_o = 1'b0;
                        2'h1: r_nxt.scl_o = 1'b1;
                        2'h2: r_nxt.sda_o = 1'b1;
                        default: r_nxt.st = I2CRA_M_END;
                    endcase
                end
            end
            I2CRA_M_END: begin
                r_nxt.st   = I2CRA_M_IDLE;
                r_nxt.busy = 1'b0;
                r_nxt.done = 1'b1;
            end
            default: r_nxt.st = I2CRA_M_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_r       <= '0;
            r_r.st    <= I2CRA_M_IDLE;
            r_r.scl_o <= 1'b1;
            r_r.sda_o <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign bus.scl_o    = r_r.scl_o;
    assign bus.scl_oe   = !r_r.scl_o;
    assign bus.sda_m_o  = r_r.sda_o;
    assign bus.sda_m_oe = !r_r.sda_o;
    assign busy         = r_r.busy;
    assign done         = r_r.done;
    assign nack         = r_r.nack;
    assign rd_data      = r_r.rdat;
endmodule

// File: verification/i2cra_chk.sv
// concurrent checks on the link that joins the master and slave ends
module i2cra_chk
    import i2cra_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_m_oe,
    input wire logic sda_s_oe
);
    // ----------------------------------------------------------------
    // frame tracking
    // ----------------------------------------------------------------
    logic       scl_q, sda_q, hit_r, rd_r, nak_r;
    logic [3:0] slot_r;
    logic [1:0] byte_r;
    logic [7:0] sh_r;
    logic       rise, start_ev, stop_ev;

    assign rise     = scl && !scl_q;
    assign start_ev = scl && scl_q && sda_q && !sda;
    assign stop_ev  = scl && scl_q && !sda_q && sda;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
            hit_r  <= 1'b0;
            rd_r   <= 1'b0;
            nak_r  <= 1'b0;
            slot_r <= 4'h0;
            byte_r <= 2'h0;
            sh_r   <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (start_ev || stop_ev) begin
                slot_r <= 4'h0;
                byte_r <= 2'h0;
                hit_r  <= 1'b0;
                rd_r   <= 1'b0;
                nak_r  <= 1'b0;
            end else if (rise && slot_r == 4'h8) begin
                slot_r <= 4'h0;
                if (byte_r != 2'h3) begin
                    byte_r <= byte_r + 2'h1;
                end
                // after a nacked read byte the next clock belongs to stop or restart
                if (byte_r != 2'h0 && rd_r && sda) begin
                    nak_r <= 1'b1;
                end
                if (byte_r == 2'h0) begin
                    hit_r <= (sh_r[7:1] == I2CRA_SLAVE_ADDR);
                    rd_r  <= sh_r[0];
                end
            end else if (rise) begin
                slot_r <= slot_r + 4'h1;
                sh_r   <= {sh_r[6:0], sda};
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_slave_drv_low: assert property ($rose(sda_s_oe) |-> !scl)
        else $error("slave took the data line while the clock was high");
    a_slave_rel_low: assert property ($fell(sda_s_oe) |-> !scl)
        else $error("slave let go of the data line while the clock was high");
    a_data_stable_high: assert property (scl && scl_q && sda != sda_q |->
        slot_r == 4'h1 || (byte_r == 2'h0 && slot_r == 4'h0))
        else $error("data line moved during a clock high inside a byte");
    a_frame_nine_clk: assert property ((start_ev || stop_ev) && byte_r != 2'h0 |->
        slot_r == 4'h1)
        else $error("frame did not end on a whole nine clock byte");
    a_addr_ack_match: assert property (rise && slot_r == 4'h8 && byte_r == 2'h0 |->
        sda_s_oe == (sh_r[7:1] == I2CRA_SLAVE_ADDR))
        else $error("address acknowledge does not follow the address match");
    a_write_byte_ack: assert property (rise && slot_r == 4'h8 && byte_r != 2'h0
        && hit_r && !rd_r |-> sda_s_oe)
        else $error("slave missed the acknowledge of a written byte");
    a_write_slave_quiet: assert property (rise && slot_r < 4'h8 && !rd_r |-> !sda_s_oe)
        else $error("slave drove a bit that the master sends");
    a_read_master_quiet: assert property (rise && slot_r < 4'h8 && byte_r != 2'h0
        && rd_r && !nak_r |-> !sda_m_oe)
        else $error("master drove a bit that the slave sends");
    a_read_last_nack: assert property (rise && slot_r == 4'h8 && byte_r != 2'h0
        && rd_r |-> !sda_m_oe && !sda_s_oe)
        else $error("last read byte was acknowledged");

    c_write_ack: cover property (rise && slot_r == 4'h8 && byte_r == 2'h2 && !rd_r);
    c_restart: cover property (start_ev && byte_r != 2'h0);
    c_read_byte: cover property (rise && slot_r == 4'h8 && rd_r && byte_r != 2'h0);
endmodule

// File: verification/i2c_register_access_slave_test.sv
// self-checking bench: master and slave joined, plus a hand-driven second link
module i2c_register_access_slave_test
    import i2cra_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk, rst_n, req, req_rd, busy, done, nack, ack;
    logic       bus_busy, wr_strobe, bus_busy2, wr_strobe2;
    logic [7:0] req_index, req_data, rd_data, wr_index, wr_data, wr_index2, wr_data2, x;
    logic [7:0] mem [256];
    logic [7:0] idx_q [$];
    logic [7:0] c_idx [4] = '{8'h00, 8'hFF, 8'h80, 8'h01};
    logic [7:0] c_dat [4] = '{8'hFF, 8'h00, 8'h01, 8'h80};
    int         n_errors, n_checks, stb_n, stb2_n, pre_n, k;

    i2cra_if u_link ();
    i2cra_if u_link2 ();

    i2cra_master u_i2cra_master (.clk(clk), .rst_n(rst_n), .bus(u_link.master), .req(req),
        .req_rd(req_rd), .req_index(req_index), .req_data(req_data), .busy(busy),
        .done(done), .nack(nack), .rd_data(rd_data));
    i2cra_slave u_i2cra_slave (.clk(clk), .rst_n(rst_n), .bus(u_link.slave),
        .bus_busy(bus_busy), .wr_strobe(wr_strobe), .wr_index(wr_index), .wr_data(wr_data));
    i2cra_slave u_i2cra_slave_b (.clk(clk), .rst_n(rst_n), .bus(u_link2.slave),
        .bus_busy(bus_busy2), .wr_strobe(wr_strobe2), .wr_index(wr_index2),
        .wr_data(wr_data2));
    i2cra_chk u_i2cra_chk (.clk(clk), .rst_n(rst_n), .scl(u_link.scl), .sda(u_link.sda),
        .sda_m_oe(u_link.sda_m_oe), .sda_s_oe(u_link.sda_s_oe));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(negedge clk) begin
        if (wr_strobe === 1'b1) stb_n++;
        if (wr_strobe2 === 1'b1) stb2_n++;
    end

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    function automatic logic [7:0] exp_read(input logic [7:0] idx);
        return mem[idx];
    endfunction

    // ----------------------------------------------------------------
    // one request through the master end
    // ----------------------------------------------------------------
    task automatic run_req(input logic rd, input logic [7:0] idx, input logic [7:0] dat);
        int i;
        int s0;
        s0 = stb_n;
        req <= 1'b1;
        req_rd <= rd;
        req_index <= idx;
        req_data <= dat;
        @(posedge clk);
        req <= 1'b0;
        for (i = 0; i < 4000 && done !== 1'b1; i++) @(negedge clk);
        if (i == 4000) begin
            n_errors++;
            finish_test();
        end
        check({7'h00, nack}, 8'h00);
        if (rd) begin
            check(rd_data, exp_read(idx));
            check(8'(stb_n - s0), 8'h00);
        end else begin
            mem[idx] = dat;
            check(8'(stb_n - s0), 8'h01);
            check(wr_index, idx);
            check(wr_data, dat);
        end
        @(posedge clk);
    endtask

    // ----------------------------------------------------------------
    // hand-driven master on the second link
    // ----------------------------------------------------------------
    task automatic bb_bit(input logic d, output logic s);
        u_link2.sda_m_oe <= !d;
        repeat (2) @(posedge clk);
        u_link2.scl_oe <= 1'b0;
        pre_n = stb2_n;
        @(posedge clk);
        @(negedge clk);
        s = u_link2.sda;
        repeat (3) @(posedge clk);
        u_link2.scl_oe <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    task automatic bb_byte(input logic [7:0] b, output logic a);
        logic s;
        for (int i = 7; i >= 0; i--) bb_bit(b[i], s);
        bb_bit(1'b1, a);
    endtask

    task automatic bb_cond(input logic is_start);
        u_link2.sda_m_oe <= !is_start;
        repeat (2) @(posedge clk);
        u_link2.scl_oe <= 1'b0;
        repeat (4) @(posedge clk);
        u_link2.sda_m_oe <= is_start;
        repeat (4) @(posedge clk);
        u_link2.scl_oe <= is_start;
        repeat (2) @(posedge clk);
    endtask

    task automatic wait_busy2(input logic lvl);
        int i;
        for (i = 0; i < 32 && bus_busy2 !== lvl; i++) @(negedge clk);
        if (i == 32) begin
            n_errors++;
            finish_test();
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        req = 1'b0;
        req_rd = 1'b0;
        req_index = 8'h00;
        req_data = 8'h00;
        u_link2.scl_o = 1'b0;
        u_link2.sda_m_o = 1'b0;
        u_link2.scl_oe = 1'b0;
        u_link2.sda_m_oe = 1'b0;
        foreach (mem[i]) mem[i] = I2CRA_REG_RESET;
        void'($urandom(3));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check({3'h0, busy, bus_busy, wr_strobe, u_link.scl, u_link.sda}, 8'h03);
        @(posedge clk);
        for (k = 0; k < 12; k++) begin
            x = (k < 4) ? c_idx[k] : 8'($urandom);
            idx_q.push_back(x);
            run_req(I2CRA_DIR_WRITE, x, (k < 4) ? c_dat[k] : 8'($urandom));
        end
        idx_q.push_back(8'h5A);
        foreach (idx_q[i]) run_req(I2CRA_DIR_READ, idx_q[i], 8'h00);
        // foreign address, both directions: no acknowledge, no write
        for (k = 0; k < 2; k++) begin
            bb_cond(1'b1);
            wait_busy2(1'b1);
            bb_byte({I2CRA_SLAVE_ADDR ^ 7'h01, k[0]}, ack);
            check({7'h00, ack}, 8'h01);
            bb_byte(8'h00, ack);
            check({7'h00, ack}, 8'h01);
            bb_cond(1'b0);
            wait_busy2(1'b0);
        end
        check(8'(stb2_n), 8'h00);
        // own address: write, repeated start write, then indexed read
        bb_cond(1'b1);
        bb_byte({I2CRA_SLAVE_ADDR, I2CRA_DIR_WRITE}, ack);
        check({7'h00, ack}, 8'h00);
        bb_byte(8'h10, ack);
        bb_byte(8'hC3, ack);
        check({7'h00, ack}, 8'h00);
        check(8'(pre_n), 8'h00);
        check(8'(stb2_n), 8'h01);
        check(wr_index2, 8'h10);
        check(wr_data2, 8'hC3);
        for (k = 0; k < 2; k++) begin
            bb_cond(1'b1);
            bb_byte({I2CRA_SLAVE_ADDR, I2CRA_DIR_WRITE}, ack);
            bb_byte(8'h11, ack);
            if (k == 0) bb_byte(8'h3C, ack);
        end
        check({6'h00, ack, bus_busy2}, 8'h01);
        check(wr_data2, 8'h3C);
        bb_cond(1'b1);
        bb_byte({I2CRA_SLAVE_ADDR, I2CRA_DIR_READ}, ack);
        check({7'h00, ack}, 8'h00);
        for (k = 7; k >= 0; k--) bb_bit(1'b1, x[k]);
        bb_bit(1'b1, ack);
        bb_cond(1'b0);
        check(x, 8'h3C);
        check({7'h00, ack}, 8'h01);
        finish_test();
    end
endmodule
